/* File: marc_attr_decode.v */
/*
  Attribute decoder: memory type, cacheability, shareability and size.
  Assumes a static attribute word from the configuration register.
*/
`timescale 1ns/1ps
`include "marc_defines.vh"
module marc_attr_decode (
  input  wire [31:0] word,
  output reg  [1:0]  mem_type,
  output reg         write_back,
  output reg         shareable,
  output wire        size_reserved
);
  wire [2:0] type_extension_bits = word[`MARC_TEX_HI:`MARC_TEX_LO];
  wire       c   = word[`MARC_C_BIT];
  wire       b   = word[`MARC_B_BIT];

  always @* begin
    mem_type   = `MARC_MT_RSVD;
    write_back = 1'b0;
    shareable  = 1'b0;
    if (type_extension_bits == 3'h0) begin
      if (!c) begin
        mem_type  = b ? `MARC_MT_DEV : `MARC_MT_SO;
        shareable = 1'b1;
      end else begin
        mem_type   = `MARC_MT_NORMAL;
        write_back = b;
        shareable  = word[`MARC_S_BIT];
      end
    end
  end

  assign size_reserved = word[`MARC_SIZE_HI:`MARC_SIZE_LO] < `MARC_SIZE_MIN;
endmodule // marc_attr_decode

/* File: marc_core_model.sv */
/* Core-side access model: issues one protection lookup per call.
   Assumes the caller enters its task just after a rising clock edge. */
`timescale 1ns/1ps
module marc_core_model (
  input  wire logic        clock,
  output logic             acc_valid, acc_write, acc_fetch, acc_priv,
  output logic [31:0]      acc_addr
);
  // ************
  // Request driver
  // ************
  initial begin
    acc_valid = 1'b0;
    acc_write = 1'b0;
    acc_fetch = 1'b0;
    acc_priv  = 1'b0;
    acc_addr  = 32'h0;
  end
  // Qualifiers are inverted once the request ends, so a stale address never passes for a live one.
  task automatic issue(input logic [31:0] a, input logic w, f, p);
    acc_valid <= 1'b1;
    acc_addr  <= a;
    acc_write <= w;
    acc_fetch <= f;
    acc_priv  <= p;
    @(posedge clock);
    acc_valid <= 1'b0;
    acc_addr  <= ~a;
    acc_write <= ~w;
    acc_fetch <= ~f;
    acc_priv  <= ~p;
  endtask
endmodule // marc_core_model

/* File: marc_defines.vh */
/*
  Constants for the region attribute checker: field positions of the region
  attribute and size word, decode codes, and the APB register map.
  Assumes it is included by bare name from the checker's design files.
*/
`ifndef MARC_DEFINES_VH
`define MARC_DEFINES_VH
// Behaviour
// - Each region is split into eight equal subregions and a mask bit of 1 disables its subregion.
// - Mask bit 8 covers the lowest-addressed subregion and bit 15 the highest, ascending between.
// - Type bits 000 with cacheable 0 decode as strongly-ordered (bufferable 0) or shared device (bufferable 1).
// - Type bits 000 with cacheable 1 decode as normal memory, write-through or write-back, no write allocate.
// - Any other type, cacheable and bufferable combination is reserved.
// - Normal memory takes shareability from the shareable bit; other types ignore it.
// - Permission 000 faults every access; 001 allows privileged read/write only.
// - Permission 010 adds unprivileged read; 011 gives full access at both levels.
// - Permission 101 is privileged read only; 110 and 111 are read only at both levels.
// - A fetch is allowed only with read permission at the current level and execute-never clear.
// - A fetch that breaks those conditions is flagged and raises the hard fault before execution.
// - The word holds execute-never at 28, permission 26:24, type 21:19, S 18, C 17, B 16, mask 15:8.
// - Region size is two to the power of size plus one; size values below 7 are reserved.
// - A region applies only when its own enable and the global enable are both 1.

// Field positions of the region attribute and size word.
`define MARC_XN_BIT        28
`define MARC_AP_HI         26
`define MARC_AP_LO         24
`define MARC_TEX_HI        21
`define MARC_TEX_LO        19
`define MARC_S_BIT         18
`define MARC_C_BIT         17
`define MARC_B_BIT         16
`define MARC_SRD_HI        15
`define MARC_SRD_LO        8
`define MARC_SIZE_HI       5
`define MARC_SIZE_LO       1
`define MARC_EN_BIT        0
`define MARC_SIZE_MIN      5'd7
`define MARC_WORD_MASK     32'h17ffff3f

// Memory type codes.
`define MARC_MT_SO         2'd0
`define MARC_MT_DEV        2'd1
`define MARC_MT_NORMAL     2'd2
`define MARC_MT_RSVD       2'd3

// APB register byte offsets.
`define MARC_OFS_WORD      12'h000
`define MARC_OFS_BASE      12'h004
`define MARC_OFS_CTRL      12'h008
`define MARC_OFS_STATUS    12'h00c
`define MARC_OFS_MASK      12'h010
`define MARC_OFS_RESULT    12'h014
`define MARC_OFS_FADDR     12'h018

// Status bit positions.
`define MARC_ST_DFAULT     0
`define MARC_ST_IFAULT     1
`define MARC_ST_RSVD       2
`define MARC_ST_W          3
`endif

/* File: marc_perm_check.v */
/*
  Permission checker: decodes the permission code for one access.
  Assumes the region match has already been resolved by the caller.
*/
`timescale 1ns/1ps
module marc_perm_check (
  input  wire [2:0] ap,
  input  wire       xn,
  input  wire       priv,
  input  wire       write,
  input  wire       fetch,
  output reg        fault
);
  reg rd_ok;
  reg wr_ok;

  always @* begin
    rd_ok = 1'b0;
    wr_ok = 1'b0;
    case (ap)
      3'h1: begin rd_ok = priv; wr_ok = priv; end
      3'h2: begin rd_ok = 1'b1; wr_ok = priv; end
      3'h3: begin rd_ok = 1'b1; wr_ok = 1'b1; end
      3'h5: begin rd_ok = priv; end
      3'h6, 3'h7: begin rd_ok = 1'b1; end
      default: begin rd_ok = 1'b0; wr_ok = 1'b0; end
    endcase
    if (fetch)
      fault = !rd_ok || xn;
    else
      fault = write ? !wr_ok : !rd_ok;
  end
endmodule // marc_perm_check

/* File: marc_region_check.v */
/*
  Region attribute check for one protection region, with an APB register
  file holding the attribute word, the region base and the global enable.
  Assumes core access requests are synchronous to clock and held one cycle.
*/
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "marc_defines.vh"
module marc_region_check (
  input  wire        clock,
  input  wire        arst_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        acc_valid,
  input  wire [31:0] acc_addr,
  input  wire        acc_write,
  input  wire        acc_fetch,
  input  wire        acc_priv,
  output reg         acc_done,
  output reg         acc_hit,
  output reg         acc_fault,
  output reg         fetch_error,
  output reg         hard_fault_exception,
  output reg  [1:0]  hit_mem_type,
  output reg         hit_shareable,
  output reg         hit_write_back,
  output reg         irq
);
  // ********************************************************
  // Registers
  // ********************************************************
  reg  [31:0] region_attribute_size_word_q;
  reg  [31:0] base_q;
  reg         protection_unit_global_enable_q;
  reg  [3:0]  status_q;
  reg  [3:0]  mask_q;
  reg  [31:0] fault_addr_q;

  wire [2:0]  access_permission_code = region_attribute_size_word_q[`MARC_AP_HI:`MARC_AP_LO];
  wire        execute_never_flag     = region_attribute_size_word_q[`MARC_XN_BIT];
  wire [7:0]  subregion_disable_mask =
              region_attribute_size_word_q[`MARC_SRD_HI:`MARC_SRD_LO];
  wire [4:0]  size_field = region_attribute_size_word_q[`MARC_SIZE_HI:`MARC_SIZE_LO];

  wire [1:0]  mem_type;
  wire        write_back;
  wire        shareable;
  wire        size_reserved;
  wire        perm_fault;

  marc_attr_decode u_dec (
    .word          (region_attribute_size_word_q),
    .mem_type      (mem_type),
    .write_back    (write_back),
    .shareable     (shareable),
    .size_reserved (size_reserved)
  );

  marc_perm_check u_perm (
    .ap    (access_permission_code),
    .xn    (execute_never_flag),
    .priv  (acc_priv),
    .write (acc_write),
    .fetch (acc_fetch),
    .fault (perm_fault)
  );

  // ********************************************************
  // Region match
  // ********************************************************
  // Size 2^(size+1) bytes; size 31 spans the full 4 GB space.
  // The sum is six bits wide so that size 31 does not wrap to a zero shift.
  wire [5:0]  size_p1   = {1'b0, size_field} + 6'd1;
  wire [32:0] span      = 33'h1 << size_p1;
  wire [31:0] size_mask = span[31:0] - 32'h1;
  wire [31:0] offset    = acc_addr & size_mask;
  wire        in_region = (acc_addr & ~size_mask) == (base_q & ~size_mask);
  // Subregion index is the top three offset bits: offset >> (size - 2).
  wire [4:0]  sub_shift = size_field - 5'd2;
  wire [31:0] sub_wide  = offset >> sub_shift;
  wire [2:0]  sub_idx   = sub_wide[2:0];
  wire        sub_off   = subregion_disable_mask[sub_idx];
  wire        region_on = region_attribute_size_word_q[`MARC_EN_BIT] &&
                          protection_unit_global_enable_q;
  wire        hit       = region_on && !size_reserved && in_region && !sub_off;
  wire        fault_now = acc_valid && hit && perm_fault;
  wire        ifault    = fault_now && acc_fetch;
  wire        dfault    = fault_now && !acc_fetch;
  wire        rsvd_ev   = acc_valid && hit && (mem_type == `MARC_MT_RSVD);
  wire        wr_ev     = acc_valid && hit && acc_write && !perm_fault;

  // ********************************************************
  // APB slave
  // ********************************************************
  // A write lands only at the edge that completes the transfer, with pready high.
  wire        wr_acc = psel && penable && pwrite && pready;
  wire        rd_set = psel && !penable;
  wire        known  = paddr == `MARC_OFS_WORD || paddr == `MARC_OFS_BASE ||
                       paddr == `MARC_OFS_CTRL || paddr == `MARC_OFS_STATUS ||
                       paddr == `MARC_OFS_MASK || paddr == `MARC_OFS_RESULT ||
                       paddr == `MARC_OFS_FADDR;
  reg  [31:0] rd_d;
  reg  [3:0]  ev;

  always @* begin
    case (paddr)
      `MARC_OFS_WORD:   rd_d = region_attribute_size_word_q;
      `MARC_OFS_BASE:   rd_d = base_q;
      `MARC_OFS_CTRL:   rd_d = {31'h0, protection_unit_global_enable_q};
      `MARC_OFS_STATUS: rd_d = {28'h0, status_q};
      `MARC_OFS_MASK:   rd_d = {28'h0, mask_q};
      `MARC_OFS_RESULT: rd_d = {27'h0, size_reserved, write_back, shareable, mem_type};
      `MARC_OFS_FADDR:  rd_d = fault_addr_q;
      default:          rd_d = 32'h0;
    endcase
    ev = 4'h0;
    ev[`MARC_ST_DFAULT] = dfault;
    ev[`MARC_ST_IFAULT] = ifault;
    ev[`MARC_ST_RSVD]   = rsvd_ev;
    ev[`MARC_ST_W]      = wr_ev;
  end

  // One wait state: setup, access with pready low, then access with pready high.
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pready                          <= 1'b0;
      pslverr                         <= 1'b0;
      prdata                          <= 32'h0;
      region_attribute_size_word_q    <= 32'h0;
      base_q                          <= 32'h0;
      protection_unit_global_enable_q <= 1'b0;
      mask_q                          <= 4'h0;
      status_q                        <= 4'h0;
      irq                             <= 1'b0;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !known;
      if (rd_set)
        prdata <= rd_d;
      if (wr_acc && paddr == `MARC_OFS_WORD)
        region_attribute_size_word_q <= pwdata & `MARC_WORD_MASK;
      if (wr_acc && paddr == `MARC_OFS_BASE)
        base_q <= {pwdata[31:5], 5'h0};
      if (wr_acc && paddr == `MARC_OFS_CTRL)
        protection_unit_global_enable_q <= pwdata[0];
      if (wr_acc && paddr == `MARC_OFS_MASK)
        mask_q <= pwdata[3:0];
      // A new event in the same cycle as its clear keeps the bit set.
      if (wr_acc && paddr == `MARC_OFS_STATUS)
        status_q <= (status_q & ~pwdata[3:0]) | ev;
      else
        status_q <= status_q | ev;
      irq <= |(status_q & mask_q);
    end
  end

  // ********************************************************
  // Access result
  // ********************************************************
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      acc_done             <= 1'b0;
      acc_hit              <= 1'b0;
      acc_fault            <= 1'b0;
      fetch_error          <= 1'b0;
      hard_fault_exception <= 1'b0;
      hit_mem_type         <= `MARC_MT_SO;
      hit_shareable        <= 1'b0;
      hit_write_back       <= 1'b0;
      fault_addr_q         <= 32'h0;
    end else begin
      acc_done             <= acc_valid;
      acc_hit              <= acc_valid && hit;
      acc_fault            <= fault_now;
      fetch_error          <= ifault;
      hard_fault_exception <= ifault;
      hit_mem_type         <= hit ? mem_type : `MARC_MT_SO;
      hit_shareable        <= hit && shareable;
      hit_write_back       <= hit && write_back;
      if (fault_now)
        fault_addr_q <= acc_addr;
    end
  end
endmodule // marc_region_check

/* File: marc_region_check_props.sv */
/* Assertions on the region check top module ports.
   Assumes the attribute word changes only by APB writes to offset 0. */
`timescale 1ns/1ps
module marc_region_check_props (
  input wire logic        clock, arst_n, psel, penable, pwrite, pready,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        acc_valid, acc_write, acc_fetch, acc_done, acc_hit, acc_fault,
  input wire logic        fetch_error, hard_fault_exception, hit_shareable,
  input wire logic [1:0]  hit_mem_type
);
  // ************
  // Shadow word and properties
  // ************
  logic [31:0] attr_q;
  wire  [2:0]  ap = attr_q[26:24];
  wire  [4:0]  key = {attr_q[21:19], attr_q[17:16]};
  wire  [1:0]  exp_type = key > 5'h3 ? 2'h3 : key[1] ? 2'h2 : {1'b0, key[0]};
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n)
      attr_q <= 32'h0;
    else if (psel && penable && pready && pwrite && paddr == 12'h000)
      attr_q <= pwdata;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_wait_ready;
    psel && penable && !pready ##1 psel && penable && pready;
  endsequence
  a_apb_one_wait: assert property (s_setup |=> s_wait_ready) else $error("apb wait wrong");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
  a_done_latency: assert property (acc_valid |=> acc_done) else $error("no done");
  a_done_cause: assert property (acc_done |-> $past(acc_valid)) else $error("stray done");
  a_fault_on_hit: assert property (acc_fault |-> acc_hit) else $error("fault on miss");
  a_fetch_hard_fault: assert property (fetch_error |-> hard_fault_exception && acc_fault && $past(acc_fetch)) else $error("fetch error");
  a_ap_none: assert property (acc_valid && (ap == 3'h0 || ap == 3'h4) |=> !acc_hit || acc_fault) else $error("no-access code");
  a_full_access: assert property (acc_valid && ap == 3'h3 && !acc_fetch |=> !acc_fault) else $error("full access");
  a_ro_write: assert property (acc_valid && acc_write && ap[2] |=> !acc_hit || acc_fault) else $error("read-only write");
  a_xn_fetch: assert property (acc_valid && acc_fetch && attr_q[28] |=> !acc_hit || fetch_error) else $error("xn fetch");
  a_type_decode: assert property (acc_hit |-> hit_mem_type == exp_type) else $error("mem type");
  a_normal_share: assert property (acc_hit && exp_type == 2'h2 |-> hit_shareable == attr_q[18]) else $error("share");
endmodule // marc_region_check_props
bind marc_region_check marc_region_check_props chk_u (.clock(clock), .arst_n(arst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready), .paddr(paddr),
  .pwdata(pwdata), .acc_valid(acc_valid), .acc_write(acc_write), .acc_fetch(acc_fetch),
  .acc_done(acc_done), .acc_hit(acc_hit), .acc_fault(acc_fault), .fetch_error(fetch_error),
  .hard_fault_exception(hard_fault_exception), .hit_shareable(hit_shareable),
  .hit_mem_type(hit_mem_type));

/* File: test_mpu_region_attribute_check.sv */
/* Bench: random region words and lookups against a reference, plus interrupt.
   Assumes the core model and checker are compiled first. */
`timescale 1ns/1ps
module test_mpu_region_attribute_check;
  logic        clock, arst_n, psel, penable, pwrite, pready, pslverr, slv, gen;
  logic        acc_valid, acc_write, acc_fetch, acc_priv, acc_done, acc_hit, acc_fault;
  logic        fetch_error, hard_fault_exception, hit_shareable, hit_write_back, irq;
  logic [1:0]  hit_mem_type;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, word, base, acc_addr, r;
  integer      n_mismatch, n_tests, seed, i, j, k;
  marc_region_check dut_u (.clock(clock), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .acc_valid(acc_valid), .acc_addr(acc_addr), .acc_write(acc_write),
    .acc_fetch(acc_fetch), .acc_priv(acc_priv), .acc_done(acc_done), .acc_hit(acc_hit),
    .acc_fault(acc_fault), .fetch_error(fetch_error), .hit_mem_type(hit_mem_type),
    .hard_fault_exception(hard_fault_exception), .hit_shareable(hit_shareable),
    .hit_write_back(hit_write_back), .irq(irq));
  marc_core_model core_u (.clock(clock), .acc_valid(acc_valid), .acc_write(acc_write),
    .acc_fetch(acc_fetch), .acc_priv(acc_priv), .acc_addr(acc_addr));
  // ************
  // Tasks and reference
  // ************
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  task automatic results;
    if (n_mismatch == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 8);
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 8) begin
      n_mismatch++;
      results();
    end
    // One idle edge, so that a following call never drives psel twice in one time step.
    @(posedge clock);
  endtask
  function automatic logic [7:0] expect_fn(input logic [31:0] w, b, a, input logic g, wr, f, p);
    logic [4:0] s;
    logic [4:0] key;
    logic [2:0] ap;
    logic [1:0] mt;
    logic       hit, rd_ok, wr_ok, flt;
    s = w[5:1];
    ap = w[26:24];
    key = {w[21:19], w[17:16]};
    hit = g && w[0] && s >= 5'd7 && (a >> (s + 1)) == (b >> (s + 1)) && !w[8 + ((a >> (s - 2)) & 7)];
    rd_ok = p ? (ap != 3'h0 && ap != 3'h4) : ap[1];
    wr_ok = p ? (!ap[2] && ap != 3'h0) : ap == 3'h3;
    flt = f ? (!rd_ok || w[28]) : (wr ? !wr_ok : !rd_ok);
    mt = key > 5'h3 ? 2'h3 : key[1] ? 2'h2 : {1'b0, key[0]};
    return {hit, hit && flt, {2{hit && f && flt}}, hit ? mt : 2'h0,
            hit && (mt < 2'h2 || (mt == 2'h2 && w[18])), hit && mt == 2'h2 && w[16]};
  endfunction
  task automatic look(input logic [31:0] a, input logic w, f, p);
    logic [8:0] e, m;
    e = {1'b1, expect_fn(word, base, a, gen, w, f, p)};
    m = e[3:2] == 2'h3 ? 9'h1fc : 9'h1ff;
    core_u.issue(a, w, f, p);
    @(posedge clock);
    check({acc_done, acc_hit, acc_fault, fetch_error, hard_fault_exception, hit_mem_type,
           hit_shareable, hit_write_back} & m, e & m);
  endtask
  // ************
  // Main sequence
  // ************
  initial begin
    seed = 36928;
    n_mismatch = 0;
    n_tests = 0;
    {arst_n, psel, penable, pwrite, paddr, pwdata, base, gen} = '0;
    word = 32'h0000000f;
    repeat (6) @(posedge clock);
    arst_n <= 1'b1;
    apb(1'b0, 12'h020, 32'h0);
    check(rd, 32'h0);
    check(slv, 1'b1);
    gen = 1'b1;
    apb(1'b1, 12'h008, 32'h1);
    apb(1'b1, 12'h000, word);
    apb(1'b1, 12'h004, 32'h0);
    apb(1'b1, 12'h010, 32'h0);
    look(32'h10, 1'b0, 1'b0, 1'b1);
    repeat (2) @(posedge clock);
    check(irq, 1'b0);
    apb(1'b1, 12'h010, 32'h1);
    repeat (2) @(posedge clock);
    check(irq, 1'b1);
    apb(1'b1, 12'h00c, 32'h1);
    repeat (2) @(posedge clock);
    check(irq, 1'b0);
    for (i = 0; i < 200; i++) begin
      word = $random(seed) & 32'h17ffff3f;
      word[5:1] = (i % 10 == 3) ? 5'd6 : (i % 10 == 7) ? 5'd31 : 5'd7 + 5'({$random(seed)} % 6);
      if ({$random(seed)} % 4 != 0) word[21:19] = 3'h0;
      word[0] = i % 8 != 0;
      gen = i % 16 != 5;
      base = $random(seed) << (word[5:1] + 1);
      apb(1'b1, 12'h008, {31'h0, gen});
      apb(1'b1, 12'h000, word);
      apb(1'b1, 12'h004, base);
      apb(1'b0, 12'h000, 32'h0);
      check(rd, word);
      for (j = 0; j < 8; j++) begin
        r = $random(seed);
        if (j == 0 && r[5]) look(base - 4, 1'b0, 1'b0, r[3]);
        look(base + (j << (word[5:1] - 2)) + (r[12:8]), !(r[0] && r[1]) && r[2], r[0] && r[1], r[3]);
      end
    end
    results();
  end
endmodule // test_mpu_region_attribute_check
